// ---- bench/charger_event_flag_mask_unit_tb.sv ----
// self-checking bench for the charger event flag and mask unit
`timescale 1ns/1ps
`include "charger_event_regs.svh"

`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin failures++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end

module charger_event_flag_mask_unit_tb;
  import charger_event_pkg::*;
  localparam int unsigned PC = 5;
  logic        core_clk, srst, ce, adc_one_shot, conv_done, iac, vac, wd, pg, rev, sync;
  logic [7:1]  flt;
  logic [2:0]  chg_st, ts_st;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, d, ef;
  logic        reg_wr, reg_rd, reg_reset_cmd, flag_rd, cc_flag, wd_flag, int_n, ecc, ewd;
  logic [7:0]  m[3];
  logic [7:0]  ad[3] = '{`CHG_MASK_A_ADDR, `CHG_MASK_B_ADDR, `FAULT_MASK_ADDR};
  logic [7:0]  wm[3] = '{`CHG_MASK_A_WMASK, `CHG_MASK_B_WMASK, `FAULT_MASK_WMASK};
  int          bp[16] = '{7, 6, 5, 4, 3, 2, 1, 7, 6, 5, 3, 0, 7, 4, 3, 1};
  int          failures, total_checks, ev, sel;
  logic [31:0] seed;

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  charger_event_flag_mask_unit #(.PULSE_CYCLES(PC)) u_dut (
    .core_clk, .srst, .ce, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .reg_reset_cmd, .input_undervolt_active(flt[7]), .input_overvolt_active(flt[6]),
    .battery_overcurrent_active(flt[5]), .battery_overvolt_active(flt[4]),
    .thermal_shutdown_active(flt[3]), .safety_timer_expired(flt[2]),
    .gate_driver_supply_bad(flt[1]), .conv_done, .adc_one_shot,
    .input_current_reg_active(iac), .input_voltage_reg_active(vac), .watchdog_status(wd),
    .charge_state(chg_st), .input_power_good(pg), .thermistor_state_field(ts_st),
    .reverse_mode_active(rev), .switching_sync_pin(sync), .charger_flag_read(flag_rd),
    .charge_cycle_flag(cc_flag), .bus_watchdog_flag(wd_flag), .int_n
  );

  event_host_model u_host (
    .core_clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_reset_cmd,
    .charger_flag_read(flag_rd), .reg_rdata
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : xs

  task automatic summarize();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize

  // one event on source ev; fault and rise-event levels return low after one cycle, pg, rev, sync and state fields keep their new value
  task automatic fire(input int e);
    if (e < 7) begin
      flt[bp[e]] <= 1'b1;
    end
    case (e)
      7:  conv_done <= 1'b1;
      8:  iac <= 1'b1;
      9:  vac <= 1'b1;
      10: wd <= 1'b1;
      11: chg_st <= chg_st + 3'h1;
      12: pg <= ~pg;
      13: ts_st <= ts_st + 3'h1;
      14: rev <= ~rev;
      15: sync <= ~sync;
      default: ;
    endcase
    @(posedge core_clk);
    flt       <= 7'h00;
    conv_done <= 1'b0;
    iac       <= 1'b0;
    vac       <= 1'b0;
    wd        <= 1'b0;
  endtask : fire

  task automatic pulse_chk(input bit want);
    int n;
    for (n = 0; n < 6 && int_n !== 1'b0; n++)
      @(posedge core_clk);
    if (!want) begin
      `CHK("int_n quiet", 1'b1, int_n)
      return;
    end
    `CHK("pulse start", 1'b0, int_n)
    if (int_n !== 1'b0)
      summarize();
    n = 0;
    while (int_n === 1'b0 && n < 64) begin
      n++;
      @(posedge core_clk);
    end
    `CHK("pulse width", PC, n)
    if (n >= 64)
      summarize();
  endtask : pulse_chk

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {srst, ce, adc_one_shot} = 3'h7;
    {conv_done, iac, vac, wd, pg, rev, sync} = 7'h00;
    {flt, chg_st, ts_st} = 13'h0000;
    {failures, total_checks} = '0;
    seed = 32'h0000000f;
    ef = 8'h00;
    ecc = 1'b0;
    ewd = `WD_FLAG_RESET;
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    repeat (2) @(posedge core_clk);
    `CHK("int_n idle", 1'b1, int_n)
    `CHK("wd flag reset", ewd, wd_flag)
    for (int a = 'h27; a <= 'h2a; a++) begin
      u_host.rd(8'(a), d);
      `CHK("reset value", 8'h00, d)
    end
    u_host.wr(`FAULT_FLAGS_ADDR, 8'hff);
    u_host.rd(`FAULT_FLAGS_ADDR, d);
    `CHK("flags not writable", 8'h00, d)
    u_host.rd(8'h3c, d);
    `CHK("unmapped read", `UNMAPPED_RDATA, d)
    for (int it = 0; it < 64; it++) begin
      for (int r = 0; r < 3; r++) begin
        seed = xs(seed);
        m[r] = seed[7:0] & wm[r];
        u_host.wr(ad[r], seed[7:0]);
        u_host.rd(ad[r], d);
        `CHK("mask readback", m[r], d)
      end
      seed = xs(seed);
      ev = int'(seed[3:0]);
      sel = (ev < 7) ? 2 : ((ev < 12) ? 0 : 1);
      adc_one_shot <= seed[4];
      fire(ev);
      pulse_chk(!m[sel][bp[ev]] && (ev != 7 || seed[4]));
      if (ev < 7) begin
        ef[bp[ev]] = 1'b1;
      end
      ecc = ecc | (ev == 11);
      ewd = ewd | (ev == 10);
      u_host.rd(`FAULT_FLAGS_ADDR, d);
      `CHK("fault flags", ef, d)
      ef = 8'h00;
      u_host.rd(`FAULT_FLAGS_ADDR, d);
      `CHK("flags after read", ef, d)
      `CHK("charge cycle flag", ecc, cc_flag)
      `CHK("watchdog flag", ewd, wd_flag)
      u_host.strobe(1'b0);
      {ecc, ewd} = 2'h0;
      `CHK("charger flags cleared", 2'h0, {cc_flag, wd_flag})
    end
    // clock enable low hides an event
    ce <= 1'b0;
    fire(0);
    ce <= 1'b1;
    pulse_chk(1'b0);
    u_host.rd(`FAULT_FLAGS_ADDR, d);
    `CHK("flags with ce low", 8'h00, d)
    // steady timer level flags once, read clears it
    u_host.wr(`FAULT_MASK_ADDR, 8'h04);
    flt[2] <= 1'b1;
    @(posedge core_clk);
    u_host.rd(`FAULT_FLAGS_ADDR, d);
    `CHK("timer flag", 8'h04, d)
    u_host.rd(`FAULT_FLAGS_ADDR, d);
    `CHK("timer level", 8'h00, d)
    flt <= 7'h00;
    pulse_chk(1'b0);
    for (int r = 0; r < 3; r++)
      u_host.wr(ad[r], 8'hff);
    u_host.strobe(1'b1);
    for (int r = 0; r < 3; r++) begin
      u_host.rd(ad[r], d);
      `CHK("mask after reset cmd", 8'h00, d)
    end
    summarize();
  end
endmodule : charger_event_flag_mask_unit_tb

// ---- bench/event_host_model.sv ----
// host-side register access model for the event unit
`timescale 1ns/1ps

module event_host_model (
  // clock
  input  wire logic       core_clk,
  // register port
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_wdata,
  output logic            reg_reset_cmd,
  output logic            charger_flag_read,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr          = 8'h00;
    reg_wr            = 1'b0;
    reg_rd            = 1'b0;
    reg_wdata         = 8'h00;
    reg_reset_cmd     = 1'b0;
    charger_flag_read = 1'b0;
  end

  // write data is scrambled once the strobe drops
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
    @(posedge core_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    @(posedge core_clk);
    d = reg_rdata;
  endtask : rd

  // sel high: register reset, low: charger flag read
  task automatic strobe(input bit sel);
    if (sel) begin
      reg_reset_cmd <= 1'b1;
    end else begin
      charger_flag_read <= 1'b1;
    end
    @(posedge core_clk);
    reg_reset_cmd     <= 1'b0;
    charger_flag_read <= 1'b0;
    @(posedge core_clk);
  endtask : strobe
endmodule : event_host_model

// ---- include/charger_event_pkg.sv ----
// types shared by the charger event flag and mask unit
package charger_event_pkg;

  typedef logic [7:0] reg_byte_t;

  typedef enum logic [1:0] {
    PULSE_IDLE,
    PULSE_LOW,
    PULSE_GAP
  } pulse_state_e;

endpackage : charger_event_pkg

// ---- include/charger_event_regs.svh ----
// register offsets, field positions, reset values and timing counts
`ifndef CHARGER_EVENT_REGS_SVH
`define CHARGER_EVENT_REGS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define FAULT_FLAGS_ADDR     8'h27
`define CHG_MASK_A_ADDR      8'h28
`define CHG_MASK_B_ADDR      8'h29
`define FAULT_MASK_ADDR      8'h2a

// ----------------------------------------------------------------
// fault flag and fault mask bit positions
// ----------------------------------------------------------------
`define FLT_UV_BIT           7
`define FLT_OV_BIT           6
`define FLT_BAT_OC_BIT       5
`define FLT_BAT_OV_BIT       4
`define FLT_TSHUT_BIT        3
`define FLT_TMR_BIT          2
`define FLT_DRV_BIT          1
`define FLT_RSVD_BIT         0

// ----------------------------------------------------------------
// charger mask bit positions
// ----------------------------------------------------------------
`define MSKA_CONV_BIT        7
`define MSKA_IAC_BIT         6
`define MSKA_VAC_BIT         5
`define MSKA_WD_BIT          3
`define MSKA_CHG_BIT         0
`define MSKB_PG_BIT          7
`define MSKB_TS_BIT          4
`define MSKB_REV_BIT         3
`define MSKB_SYNC_BIT        1

// ----------------------------------------------------------------
// reset values and writable bits
// ----------------------------------------------------------------
`define FAULT_FLAGS_RESET    8'h00
`define CHG_MASK_A_RESET     8'h00
`define CHG_MASK_B_RESET     8'h00
`define FAULT_MASK_RESET     8'h00
`define FAULT_MASK_WMASK     8'hfe
`define CHG_MASK_A_WMASK     8'he9
`define CHG_MASK_B_WMASK     8'h9a
`define WD_FLAG_RESET        1'b1
`define UNMAPPED_RDATA       8'h00

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS        50
`define INT_PULSE_NS         100000
`define INT_PULSE_CYCLES     ((`INT_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ---- verilog/charger_event_flag_mask_unit.sv ----
// fault flags, event masks and interrupt pulse for the charge controller
`timescale 1ns/1ps
`include "charger_event_regs.svh"

module charger_event_flag_mask_unit
  import charger_event_pkg::*;
#(
  parameter int unsigned PULSE_CYCLES = `INT_PULSE_CYCLES
) (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       srst,
  input  wire logic       ce,
  // register port from the serial bus slave
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       reg_reset_cmd,
  // fault status levels
  input  wire logic       input_undervolt_active,
  input  wire logic       input_overvolt_active,
  input  wire logic       battery_overcurrent_active,
  input  wire logic       battery_overvolt_active,
  input  wire logic       thermal_shutdown_active,
  input  wire logic       safety_timer_expired,
  input  wire logic       gate_driver_supply_bad,
  // charger event sources
  input  wire logic       conv_done,
  input  wire logic       adc_one_shot,
  input  wire logic       input_current_reg_active,
  input  wire logic       input_voltage_reg_active,
  input  wire logic       watchdog_status,
  input  wire logic [2:0] charge_state,
  input  wire logic       input_power_good,
  input  wire logic [2:0] thermistor_state_field,
  input  wire logic       reverse_mode_active,
  input  wire logic       switching_sync_pin,
  // charge-cycle and watchdog flags
  input  wire logic       charger_flag_read,
  output logic            charge_cycle_flag,
  output logic            bus_watchdog_flag,
  // interrupt pin
  output logic            int_n
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic reg_byte_t wr_merge(input reg_byte_t wdata, input reg_byte_t wmask);
    wr_merge = wdata & wmask;
  endfunction : wr_merge

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
    hit = (addr == target);
  endfunction : hit

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  reg_byte_t   fault_flags_q;
  reg_byte_t   fault_mask_q;
  reg_byte_t   chg_mask_a_q;
  reg_byte_t   chg_mask_b_q;
  reg_byte_t   fault_set;
  reg_byte_t   chg_ev_a;
  reg_byte_t   chg_ev_b;
  logic [9:0]  rise_lvl;
  logic [9:0]  rise_hit;
  logic [8:0]  chg_lvl;
  logic [8:0]  chg_hit;
  logic        fault_rd;
  logic        wr_en;
  logic        mask_clr;
  logic        int_trigger;
  logic        pulse_busy;
  logic [31:0] low_run_q;

  // ----------------------------------------------------------------
  // event detection
  // ----------------------------------------------------------------
  assign rise_lvl = {watchdog_status, input_voltage_reg_active, input_current_reg_active,
                     gate_driver_supply_bad, safety_timer_expired, thermal_shutdown_active,
                     battery_overvolt_active, battery_overcurrent_active,
                     input_overvolt_active, input_undervolt_active};

  assign chg_lvl = {switching_sync_pin, reverse_mode_active, thermistor_state_field,
                    input_power_good, charge_state};

  event_edge_detect #(
    .WIDTH     (10),
    .RISE_ONLY (1'b1)
  ) u_rise_detect (
    .core_clk  (core_clk),
    .srst      (srst),
    .ce        (ce),
    .level     (rise_lvl),
    .event_hit (rise_hit)
  );

  event_edge_detect #(
    .WIDTH     (9),
    .RISE_ONLY (1'b0)
  ) u_change_detect (
    .core_clk  (core_clk),
    .srst      (srst),
    .ce        (ce),
    .level     (chg_lvl),
    .event_hit (chg_hit)
  );

  // ----------------------------------------------------------------
  // event vectors in register bit order
  // ----------------------------------------------------------------
  always_comb begin
    fault_set                  = '0;
    fault_set[`FLT_UV_BIT]     = rise_hit[0];
    fault_set[`FLT_OV_BIT]     = rise_hit[1];
    fault_set[`FLT_BAT_OC_BIT] = rise_hit[2];
    fault_set[`FLT_BAT_OV_BIT] = rise_hit[3];
    fault_set[`FLT_TSHUT_BIT]  = rise_hit[5 - 1];
    fault_set[`FLT_TMR_BIT]    = rise_hit[5];
    fault_set[`FLT_DRV_BIT]    = rise_hit[6];
  end

  always_comb begin
    chg_ev_a                 = '0;
    chg_ev_a[`MSKA_CONV_BIT] = ce & conv_done & adc_one_shot;
    chg_ev_a[`MSKA_IAC_BIT]  = rise_hit[7];
    chg_ev_a[`MSKA_VAC_BIT]  = rise_hit[8];
    chg_ev_a[`MSKA_WD_BIT]   = rise_hit[9];
    chg_ev_a[`MSKA_CHG_BIT]  = |chg_hit[2:0];
  end

  always_comb begin
    chg_ev_b                 = '0;
    chg_ev_b[`MSKB_PG_BIT]   = chg_hit[3];
    chg_ev_b[`MSKB_TS_BIT]   = |chg_hit[6:4];
    chg_ev_b[`MSKB_REV_BIT]  = chg_hit[7];
    chg_ev_b[`MSKB_SYNC_BIT] = chg_hit[8];
  end

  // ----------------------------------------------------------------
  // register access
  // ----------------------------------------------------------------
  assign fault_rd = ce & reg_rd & hit(reg_addr, `FAULT_FLAGS_ADDR);
  assign wr_en    = ce & reg_wr;
  assign mask_clr = ce & reg_reset_cmd;

  // clear-on-read; a new event in the read cycle wins over the clear
  always_ff @(posedge core_clk) begin
    if (srst) begin
      fault_flags_q <= `FAULT_FLAGS_RESET;
    end else if (ce) begin
      fault_flags_q <= ((fault_rd ? 8'h00 : fault_flags_q) | fault_set)
                       & `FAULT_MASK_WMASK;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst || mask_clr) begin
      fault_mask_q <= `FAULT_MASK_RESET;
    end else if (wr_en && hit(reg_addr, `FAULT_MASK_ADDR)) begin
      fault_mask_q <= wr_merge(reg_wdata, `FAULT_MASK_WMASK);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst || mask_clr) begin
      chg_mask_a_q <= `CHG_MASK_A_RESET;
    end else if (wr_en && hit(reg_addr, `CHG_MASK_A_ADDR)) begin
      chg_mask_a_q <= wr_merge(reg_wdata, `CHG_MASK_A_WMASK);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst || mask_clr) begin
      chg_mask_b_q <= `CHG_MASK_B_RESET;
    end else if (wr_en && hit(reg_addr, `CHG_MASK_B_ADDR)) begin
      chg_mask_b_q <= wr_merge(reg_wdata, `CHG_MASK_B_WMASK);
    end
  end

  // read data returns the value before any clear of the same cycle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (ce && reg_rd) begin
      case (reg_addr)
        `FAULT_FLAGS_ADDR: reg_rdata <= fault_flags_q;
        `CHG_MASK_A_ADDR:  reg_rdata <= chg_mask_a_q;
        `CHG_MASK_B_ADDR:  reg_rdata <= chg_mask_b_q;
        `FAULT_MASK_ADDR:  reg_rdata <= fault_mask_q;
        default:           reg_rdata <= `UNMAPPED_RDATA;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // charge-cycle and watchdog flags
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      charge_cycle_flag <= 1'b0;
    end else if (ce) begin
      charge_cycle_flag <= (charge_cycle_flag & ~charger_flag_read)
                           | chg_ev_a[`MSKA_CHG_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      bus_watchdog_flag <= `WD_FLAG_RESET;
    end else if (ce) begin
      bus_watchdog_flag <= (bus_watchdog_flag & ~charger_flag_read)
                           | chg_ev_a[`MSKA_WD_BIT];
    end
  end

  // ----------------------------------------------------------------
  // interrupt
  // ----------------------------------------------------------------
  assign int_trigger = ce & (|(fault_set & ~fault_mask_q)
                           | |(chg_ev_a & ~chg_mask_a_q)
                           | |(chg_ev_b & ~chg_mask_b_q));

  int_pulse_gen #(
    .PULSE_CYCLES (PULSE_CYCLES)
  ) u_pulse (
    .core_clk (core_clk),
    .srst     (srst),
    .ce       (ce),
    .trigger  (int_trigger),
    .int_n    (int_n),
    .busy     (pulse_busy)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      low_run_q <= '0;
    end else if (ce) begin
      low_run_q <= int_n ? 32'd0 : low_run_q + 32'd1;
    end
  end

  uv_flag_set_a: assert property (@(posedge core_clk) disable iff (srst)
    (ce && $rose(input_undervolt_active) && $past(ce) && !$past(srst))
      |=> fault_flags_q[`FLT_UV_BIT])
    else $error("undervoltage entry did not set its flag");

  fault_rd_clear_a: assert property (@(posedge core_clk) disable iff (srst)
    (fault_rd && fault_set == 8'h00) |=> (fault_flags_q == 8'h00))
    else $error("fault flags not cleared by read");

  set_beats_clear_a: assert property (@(posedge core_clk) disable iff (srst)
    (fault_rd && fault_set[`FLT_TSHUT_BIT]) |=> fault_flags_q[`FLT_TSHUT_BIT])
    else $error("thermal flag lost when read in event cycle");

  timer_level_a: assert property (@(posedge core_clk) disable iff (srst)
    (ce && $past(ce) && safety_timer_expired && $past(safety_timer_expired) && fault_rd)
      |=> !fault_flags_q[`FLT_TMR_BIT])
    else $error("timer flag set by a steady level");

  rsvd_zero_a: assert property (@(posedge core_clk) disable iff (srst)
    !fault_flags_q[`FLT_RSVD_BIT] && !fault_mask_q[0] && !chg_mask_a_q[4] && !chg_mask_b_q[0])
    else $error("reserved bit not zero");

  mask_reset_cmd_a: assert property (@(posedge core_clk) disable iff (srst)
    mask_clr |=> (chg_mask_a_q == 8'h00 && chg_mask_b_q == 8'h00 && fault_mask_q == 8'h00))
    else $error("register reset left a mask set");

  masked_quiet_a: assert property (@(posedge core_clk) disable iff (srst)
    (!pulse_busy && $past(!pulse_busy) && $past(ce) && int_n && ce
      && chg_ev_a == (8'h01 << `MSKA_IAC_BIT)
      && chg_mask_a_q[`MSKA_IAC_BIT] && fault_set == 8'h00 && chg_ev_b == 8'h00)
      |=> int_n)
    else $error("masked current regulation event pulsed");

  unmasked_pulse_a: assert property (@(posedge core_clk) disable iff (srst)
    (!pulse_busy && int_trigger) |=> !int_n)
    else $error("unmasked event did not start a pulse");

  pulse_width_a: assert property (@(posedge core_clk) disable iff (srst)
    $rose(int_n) |-> (low_run_q == PULSE_CYCLES))
    else $error("interrupt pulse width wrong");

  pulse_bound_a: assert property (@(posedge core_clk) disable iff (srst)
    low_run_q <= PULSE_CYCLES)
    else $error("interrupt held low too long");

  chg_cycle_a: assert property (@(posedge core_clk) disable iff (srst)
    (ce && chg_hit[2:0] != 3'b000) |=> charge_cycle_flag)
    else $error("charge state change did not set flag");

  wd_reset_a: assert property (@(posedge core_clk)
    srst |=> bus_watchdog_flag)
    else $error("watchdog flag not one after reset");

  mask_rdback_a: assert property (@(posedge core_clk) disable iff (srst)
    (ce && reg_rd && reg_addr == `FAULT_MASK_ADDR && !mask_clr)
      |=> (reg_rdata == $past(fault_mask_q)))
    else $error("fault mask read back wrong");

  // a low clock enable holds flags, masks and the pin
  ce_freeze_a: assert property (@(posedge core_clk) disable iff (srst)
    !ce |=> ($stable(fault_flags_q) && $stable(int_n) && $stable(chg_mask_a_q)))
    else $error("state moved while clock enable low");

  wd_rise_a: assert property (@(posedge core_clk) disable iff (srst)
    (ce && rise_hit[9]) |=> bus_watchdog_flag)
    else $error("watchdog rise did not set flag");

  // idle for two cycles means no folded request is waiting
  fault_mask_quiet_a: assert property (@(posedge core_clk) disable iff (srst)
    (!pulse_busy && $past(!pulse_busy) && $past(ce) && int_n && fault_set != 8'h00
      && (fault_set & ~fault_mask_q) == 8'h00 && chg_ev_a == 8'h00 && chg_ev_b == 8'h00)
      |=> int_n)
    else $error("masked fault event pulsed");

endmodule : charger_event_flag_mask_unit

// ---- verilog/event_edge_detect.sv ----
// per-bit rising-edge or any-change detector for status levels
`timescale 1ns/1ps

module event_edge_detect #(
  parameter int unsigned WIDTH     = 1,
  parameter bit          RISE_ONLY = 1'b1
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             srst,
  input  wire logic             ce,
  // levels in, one-cycle events out
  input  wire logic [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] event_hit
);

  logic [WIDTH-1:0] prev_q;
  logic             primed_q;

  // first cycle after reset only loads the history, so a level that
  // is already high at reset does not count as an edge
  always_ff @(posedge core_clk) begin
    if (srst) begin
      prev_q   <= '0;
      primed_q <= 1'b0;
    end else if (ce) begin
      prev_q   <= level;
      primed_q <= 1'b1;
    end
  end

  always_comb begin
    if (!primed_q || !ce) begin
      event_hit = '0;
    end else if (RISE_ONLY) begin
      event_hit = level & ~prev_q;
    end else begin
      event_hit = level ^ prev_q;
    end
  end

endmodule : event_edge_detect

// ---- verilog/int_pulse_gen.sv ----
// active-low interrupt pulse generator with one pending request
`timescale 1ns/1ps

module int_pulse_gen
  import charger_event_pkg::*;
#(
  parameter int unsigned PULSE_CYCLES = 2000
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic srst,
  input  wire logic ce,
  // request and pin
  input  wire logic trigger,
  output logic      int_n,
  output logic      busy
);

  localparam int unsigned CNT_W = $clog2(PULSE_CYCLES + 1);

  pulse_state_e     state_q;
  logic [CNT_W-1:0] cnt_q;
  logic             pending_q;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_q <= PULSE_IDLE;
      cnt_q   <= '0;
      int_n   <= 1'b1;
    end else if (ce) begin
      case (state_q)
        PULSE_IDLE: begin
          if (trigger || pending_q) begin
            state_q <= PULSE_LOW;
            cnt_q   <= CNT_W'(PULSE_CYCLES - 1);
            int_n   <= 1'b0;
          end
        end
        PULSE_LOW: begin
          if (cnt_q == '0) begin
            state_q <= PULSE_GAP;
            int_n   <= 1'b1;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        // two high cycles, gap then idle, so back-to-back pulses stay distinct
        PULSE_GAP: begin
          state_q <= PULSE_IDLE;
        end
        default: begin
          state_q <= PULSE_IDLE;
          int_n   <= 1'b1;
        end
      endcase
    end
  end

  // events during a pulse fold into one further pulse
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pending_q <= 1'b0;
    end else if (ce) begin
      if (state_q == PULSE_IDLE) begin
        pending_q <= 1'b0;
      end else if (trigger) begin
        pending_q <= 1'b1;
      end
    end
  end

  assign busy = (state_q != PULSE_IDLE);

endmodule : int_pulse_gen
